// *** tb_top.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("unexpected at %0t: got %0h exp %0h", $time, g, e); \
	end \
end

module tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        ptr_upd_valid = 1'b0;
	logic [7:0]  ptr_upd_chan = 8'h00;
	logic [9:0]  ptr_upd_value = 10'h000;
	logic [7:0]  ptr_lookup_chan = 8'h00;
	logic [9:0]  link_lookup_block = 10'h000;
	logic        level_valid = 1'b0;
	logic [7:0]  level_chan = 8'h00;
	logic [9:0]  level_count = 10'h000;
	logic        awready, wready, bvalid, arready, rvalid, refill_req;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [9:0]  ptr_lookup_value, link_lookup_next;
	logic [7:0]  refill_chan;
	logic [11:0] regs [6] = '{12'h980, 12'h984, 12'h990, 12'h994,
		12'h9A0, 12'h9A4};
	logic [9:0]  vals [2] = '{10'h001, 10'h3FF};
	// low marks kept legal for a full chain of 1024 blocks
	logic [9:0]  marks [2] = '{10'h001, 10'h3FE};
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	always #25 aclk = ~aclk;

	tfc_top i_tfc_top (.*);

	// ---------------------------------------------------------------
	// bus tasks
	// ---------------------------------------------------------------
	// ready is judged at the negedge so the handshake edge is never raced
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic ah;
		logic wh;
		ah = 1'b0;
		wh = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			if (awvalid && awready) ah = 1'b1;
			if (wvalid && wready) wh = 1'b1;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!(ah && wh));
		do @(negedge aclk); while (!bvalid);
		`CHK(bresp, er)
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(d, e)
		`CHK(r, er)
	endtask : rdc

	task automatic poll(input logic [11:0] a);
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		n = 0;
		do begin
			rd(a, d, r);
			n++;
		end while (d[15] !== 1'b0 && n < 30);
		`CHK(d[15], 1'b0)
	endtask : poll

	task automatic lvl(input logic [9:0] cnt, input logic e);
		@(posedge aclk);
		level_valid <= 1'b1;
		level_chan <= 8'h34;
		level_count <= cnt;
		@(posedge aclk);
		level_valid <= 1'b0;
		@(posedge aclk);
		@(negedge aclk);
		`CHK(refill_req, e)
		if (e) `CHK(refill_chan, 8'h34)
	endtask : lvl

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (regs[i]) rdc(regs[i], 32'h0, 2'h0);
		wr(12'h9B0, 32'h1, 4'hF, 2'h2);
		rdc(12'h9B0, 32'h0, 2'h2);
		$display("test reset and unmapped done");
		// engine holds the start RAM, so the host write must wait
		@(posedge aclk);
		ptr_upd_valid <= 1'b1;
		ptr_upd_chan <= 8'h01;
		ptr_upd_value <= 10'h2AA;
		wr(12'h984, 32'h3FF, 4'h3, 2'h0);
		wr(12'h980, 32'h40FF, 4'h3, 2'h0);
		rdc(12'h980, 32'hC0FF, 2'h0);
		@(posedge aclk);
		ptr_upd_valid <= 1'b0;
		ptr_lookup_chan <= 8'h01;
		poll(12'h980);
		`CHK(ptr_lookup_value, 10'h2AA)
		@(posedge aclk);
		ptr_lookup_chan <= 8'hFF;
		@(posedge aclk);
		@(negedge aclk);
		`CHK(ptr_lookup_value, 10'h3FF)
		@(posedge aclk);
		ptr_upd_valid <= 1'b1;
		ptr_upd_chan <= 8'hFF;
		ptr_upd_value <= 10'h155;
		@(posedge aclk);
		ptr_upd_valid <= 1'b0;
		wr(12'h980, 32'h00FF, 4'h3, 2'h0);
		poll(12'h980);
		rdc(12'h984, 32'h155, 2'h0);
		$display("test start pointer done");
		foreach (vals[i]) begin
			wr(12'h994, {22'h0, ~vals[i]}, 4'h3, 2'h0);
			wr(12'h990, {22'h0, vals[i]}, 4'h3, 2'h0);
			poll(12'h990);
			@(posedge aclk);
			link_lookup_block <= vals[i];
			@(posedge aclk);
			@(negedge aclk);
			`CHK(link_lookup_next, ~vals[i])
			wr(12'h994, 32'h0, 4'h3, 2'h0);
			wr(12'h990, {18'h1, 4'h0, vals[i]}, 4'h3, 2'h0);
			poll(12'h990);
			rdc(12'h994, {22'h0, ~vals[i]}, 2'h0);
		end
		$display("test block link done");
		// a low-lane write moves the index but starts nothing
		wr(12'h9A0, 32'h4034, 4'h1, 2'h0);
		rdc(12'h9A0, 32'h0034, 2'h0);
		foreach (marks[i]) begin
			wr(12'h9A4, {22'h0, marks[i]}, 4'h3, 2'h0);
			wr(12'h9A0, 32'h0034, 4'h3, 2'h0);
			poll(12'h9A0);
			wr(12'h9A4, 32'h0, 4'h3, 2'h0);
			wr(12'h9A0, 32'h4034, 4'h3, 2'h0);
			poll(12'h9A0);
			rdc(12'h9A4, {22'h0, marks[i]}, 2'h0);
			lvl(marks[i] + 10'h001, 1'b0);
			lvl(marks[i], 1'b1);
		end
		$display("test low mark done");
		end_sim();
	end
endmodule : tb_top

// *** tfc_chk.sv ***
`timescale 1ns/1ns
module tfc_chk (
	input logic        aclk,
	input logic        aresetn,
	input logic        awvalid,
	input logic        awready,
	input logic        wvalid,
	input logic        wready,
	input logic        bvalid,
	input logic        arvalid,
	input logic        arready,
	input logic        rvalid,
	input logic [31:0] rdata,
	input logic        ptr_upd_valid,
	input logic [7:0]  ptr_upd_chan,
	input logic [9:0]  ptr_upd_value,
	input logic [7:0]  ptr_lookup_chan,
	input logic [9:0]  ptr_lookup_value,
	input logic        level_valid,
	input logic [7:0]  level_chan,
	input logic        refill_req,
	input logic [7:0]  refill_chan
);
	// ---------------------------------------------------------------
	// sequences
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_both;
		awvalid && awready && wvalid && wready;
	endsequence

	// lookup of the channel the engine just moved, with no update between
	sequence s_upd_look;
		ptr_upd_valid ##1
		(!ptr_upd_valid && ptr_lookup_chan == $past(ptr_upd_chan));
	endsequence

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_upd_look: assert property (
		s_upd_look |=> ptr_lookup_value == $past(ptr_upd_value, 2))
		else $error("lookup misses engine update");
	a_refill_src: assert property (
		refill_req |-> $past(level_valid, 2) &&
		refill_chan == $past(level_chan, 2))
		else $error("refill without matching report");
	a_refill_once: assert property (
		refill_req && !$past(level_valid) |=> !refill_req)
		else $error("refill pulse too long");
	// bvalid is registered off the held pair, so it is seen two edges on
	a_b_latency: assert property (
		s_wr_both |-> ##2 bvalid) else $error("write answer late");
	a_b_block: assert property (
		bvalid |-> !awready && !wready) else $error("write taken early");
	a_r_latency: assert property (
		arvalid && arready |=> rvalid) else $error("read answer late");
	a_r_block: assert property (
		rvalid |-> !arready) else $error("read taken early");
	a_rd_zero: assert property (
		rvalid |-> rdata[31:16] == 16'h0000 && rdata[13:10] == 4'h0)
		else $error("unused read bits set");
endmodule : tfc_chk

bind tfc_top tfc_chk i_tfc_chk (.*);

// *** tfc_pkg.sv ***
package tfc_pkg;

	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_START_SEL = 12'h980;
	localparam logic [11:0] OFS_START_DAT = 12'h984;
	localparam logic [11:0] OFS_LINK_SEL  = 12'h990;
	localparam logic [11:0] OFS_LINK_DAT  = 12'h994;
	localparam logic [11:0] OFS_LOW_SEL   = 12'h9A0;
	localparam logic [11:0] OFS_LOW_DAT   = 12'h9A4;

	// ---------------------------------------------------------------
	// field layout
	// ---------------------------------------------------------------
	localparam int CHAN_W   = 8;
	localparam int BLK_W    = 10;
	localparam int VAL_W    = 10;
	localparam int CMD_BIT  = 14;
	localparam int BUSY_BIT = 15;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [9:0] SEL_IDX_RST = 10'h000;
	localparam logic       SEL_CMD_RST = 1'h0;
	localparam logic [9:0] DATA_RST    = 10'h000;

	// ---------------------------------------------------------------
	// indirect targets and bus answers
	// ---------------------------------------------------------------
	localparam logic [1:0] TGT_START = 2'h0;
	localparam logic [1:0] TGT_LINK  = 2'h1;
	localparam logic [1:0] TGT_LOW   = 2'h2;
	localparam int         TGT_N     = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		S_IDLE    = 2'b00,
		S_WRITE   = 2'b01,
		S_RD_ADDR = 2'b10,
		S_RD_DATA = 2'b11
	} tfc_state_e;

endpackage : tfc_pkg

// *** tfc_ram.sv ***
`timescale 1ns/1ns
module tfc_ram #(
	parameter int AW = 8,
	parameter int DW = 10
) (
	input  logic          aclk,
	input  logic          aresetn,
	input  logic          wr_en,
	input  logic [AW-1:0] wr_addr,
	input  logic [DW-1:0] wr_data,
	input  logic [AW-1:0] a_addr,
	output logic [DW-1:0] a_data,
	input  logic [AW-1:0] b_addr,
	output logic [DW-1:0] b_data
);

	// contents carry no reset; only the read registers do
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_data <= '0;
			b_data <= '0;
		end else begin
			a_data <= mem[a_addr];
			b_data <= mem[b_addr];
		end
	end

endmodule : tfc_ram

// *** tfc_top.sv ***
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
// Functional notes
// - channel index 00h..FFh selects channels 1..256
// - start select command one writes start RAM
// - busy flag high during access, clears after
// - transmit engine may overwrite stored start pointer
// - start data read returns last fetched or host-written pointer
// - start pointer value names block 0..1023
// - link select command one fetches next-block entry
// - link select command zero stores data register
// - link block index is ten bits wide
// - low-mark command one fetches channel entry
// - low-mark command zero stores data register
// - count reaching low mark requests more data
// - low mark compared as plain block count
module tfc_top (
	input  logic        aclk,
	input  logic        aresetn,
	input  logic [11:0] awaddr,
	input  logic        awvalid,
	output logic        awready,
	input  logic [31:0] wdata,
	input  logic [3:0]  wstrb,
	input  logic        wvalid,
	output logic        wready,
	output logic [1:0]  bresp,
	output logic        bvalid,
	input  logic        bready,
	input  logic [11:0] araddr,
	input  logic        arvalid,
	output logic        arready,
	output logic [31:0] rdata,
	output logic [1:0]  rresp,
	output logic        rvalid,
	input  logic        rready,
	input  logic        ptr_upd_valid,
	input  logic [7:0]  ptr_upd_chan,
	input  logic [9:0]  ptr_upd_value,
	input  logic [7:0]  ptr_lookup_chan,
	output logic [9:0]  ptr_lookup_value,
	input  logic [9:0]  link_lookup_block,
	output logic [9:0]  link_lookup_next,
	input  logic        level_valid,
	input  logic [7:0]  level_chan,
	input  logic [9:0]  level_count,
	output logic        refill_req,
	output logic [7:0]  refill_chan
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// {hit, is_data, target}
	function automatic logic [3:0] tfc_decode(input logic [11:0] a);
		logic [3:0] r;
		r = 4'h3;
		case (a)
			tfc_pkg::OFS_START_SEL: r = {2'h2, tfc_pkg::TGT_START};
			tfc_pkg::OFS_START_DAT: r = {2'h3, tfc_pkg::TGT_START};
			tfc_pkg::OFS_LINK_SEL:  r = {2'h2, tfc_pkg::TGT_LINK};
			tfc_pkg::OFS_LINK_DAT:  r = {2'h3, tfc_pkg::TGT_LINK};
			tfc_pkg::OFS_LOW_SEL:   r = {2'h2, tfc_pkg::TGT_LOW};
			tfc_pkg::OFS_LOW_DAT:   r = {2'h3, tfc_pkg::TGT_LOW};
			default:                r = 4'h3;
		endcase
		return r;
	endfunction : tfc_decode

	function automatic logic [15:0] tfc_merge(input logic [15:0] old,
	                                          input logic [31:0] d,
	                                          input logic [3:0]  s);
		logic [15:0] r;
		r[15:8] = s[1] ? d[15:8] : old[15:8];
		r[7:0]  = s[0] ? d[7:0]  : old[7:0];
		return r;
	endfunction : tfc_merge

	// channel-indexed selects keep only eight index bits
	function automatic logic [9:0] tfc_idx_mask(input logic [1:0] t,
	                                            input logic [9:0] v);
		logic [9:0] r;
		r = (t == tfc_pkg::TGT_LINK) ? v : {2'h0, v[7:0]};
		return r;
	endfunction : tfc_idx_mask

	// start select inverts the sense of the direction bit
	function automatic logic tfc_is_write(input logic [1:0] t,
	                                      input logic       cmd);
		logic r;
		r = (t == tfc_pkg::TGT_START) ? cmd : !cmd;
		return r;
	endfunction : tfc_is_write

	// ---------------------------------------------------------------
	// bus write channel
	// ---------------------------------------------------------------
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;

	wire       do_write = aw_held_q & w_held_q & !bvalid_q;
	wire [3:0] wdec     = tfc_decode(awaddr_q);
	wire       w_hit    = wdec[3];

	assign awready = !aw_held_q & !bvalid_q;
	assign wready  = !w_held_q & !bvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'h0;
			w_held_q  <= 1'h0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'h0;
			bresp_q   <= tfc_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held_q <= 1'h1;
				awaddr_q  <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_q <= 1'h1;
				wdata_q  <= wdata;
				wstrb_q  <= wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'h0;
				w_held_q  <= 1'h0;
				bvalid_q  <= 1'h1;
				bresp_q   <= w_hit ? tfc_pkg::RESP_OKAY
				                   : tfc_pkg::RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'h0;
			end
		end
	end

	// ---------------------------------------------------------------
	// indirect access engines, one per memory
	// ---------------------------------------------------------------
	tfc_pkg::tfc_state_e state_q [tfc_pkg::TGT_N];
	tfc_pkg::tfc_state_e state_d [tfc_pkg::TGT_N];
	logic [9:0]          idx_q   [tfc_pkg::TGT_N];
	logic [9:0]          idx_d   [tfc_pkg::TGT_N];
	logic                cmd_q   [tfc_pkg::TGT_N];
	logic                cmd_d   [tfc_pkg::TGT_N];
	logic [9:0]          data_q  [tfc_pkg::TGT_N];
	logic [9:0]          data_d  [tfc_pkg::TGT_N];
	logic [9:0]          ram_rd  [tfc_pkg::TGT_N];
	logic [2:0]          busy;
	logic [2:0]          ram_we;

	// engine pointer updates own the start memory write port
	wire [2:0] wr_block = {2'h0, ptr_upd_valid};

	always_comb begin
		for (int i = 0; i < tfc_pkg::TGT_N; i++) begin
			busy[i]   = (state_q[i] != tfc_pkg::S_IDLE);
			ram_we[i] = (state_q[i] == tfc_pkg::S_WRITE) && !wr_block[i];
		end
	end

	always_comb begin
		logic [15:0] sel_new;
		logic [15:0] dat_new;
		logic [1:0]  t;
		logic        hw;
		sel_new = 16'h0000;
		dat_new = 16'h0000;
		t       = 2'h0;
		hw      = 1'h0;
		for (int i = 0; i < tfc_pkg::TGT_N; i++) begin
			t          = 2'(i);
			hw         = do_write && w_hit && (wdec[1:0] == t);
			state_d[i] = state_q[i];
			idx_d[i]   = idx_q[i];
			cmd_d[i]   = cmd_q[i];
			data_d[i]  = data_q[i];
			sel_new    = tfc_merge({1'h0, cmd_q[i], 4'h0, idx_q[i]},
			                       wdata_q, wstrb_q);
			dat_new    = tfc_merge({6'h00, data_q[i]}, wdata_q, wstrb_q);
			unique case (state_q[i])
				tfc_pkg::S_IDLE: begin
					if (hw && !wdec[2]) begin
						idx_d[i] = tfc_idx_mask(t, sel_new[9:0]);
						cmd_d[i] = sel_new[tfc_pkg::CMD_BIT];
						// the command lives in the upper byte lane
						if (wstrb_q[1]) begin
							if (tfc_is_write(t, cmd_d[i])) begin
								state_d[i] = tfc_pkg::S_WRITE;
							end else begin
								state_d[i] = tfc_pkg::S_RD_ADDR;
							end
						end
					end else if (hw) begin
						data_d[i] = dat_new[9:0];
					end
				end
				tfc_pkg::S_WRITE: begin
					if (!wr_block[i]) begin
						state_d[i] = tfc_pkg::S_IDLE;
					end
				end
				tfc_pkg::S_RD_ADDR: begin
					state_d[i] = tfc_pkg::S_RD_DATA;
				end
				tfc_pkg::S_RD_DATA: begin
					data_d[i]  = ram_rd[i];
					state_d[i] = tfc_pkg::S_IDLE;
				end
			endcase
		end
	end

	// writes that land while busy are dropped by the idle-only decode
	always_ff @(posedge aclk) begin
		for (int i = 0; i < tfc_pkg::TGT_N; i++) begin
			if (!aresetn) begin
				state_q[i] <= tfc_pkg::S_IDLE;
				idx_q[i]   <= tfc_pkg::SEL_IDX_RST;
				cmd_q[i]   <= tfc_pkg::SEL_CMD_RST;
				data_q[i]  <= tfc_pkg::DATA_RST;
			end else begin
				state_q[i] <= state_d[i];
				idx_q[i]   <= idx_d[i];
				cmd_q[i]   <= cmd_d[i];
				data_q[i]  <= data_d[i];
			end
		end
	end

	// ---------------------------------------------------------------
	// memories
	// ---------------------------------------------------------------
	wire       start_we   = ram_we[0] | ptr_upd_valid;
	wire [7:0] start_wa   = ptr_upd_valid ? ptr_upd_chan : idx_q[0][7:0];
	wire [9:0] start_wd   = ptr_upd_valid ? ptr_upd_value : data_q[0];
	logic [9:0] low_mark_b;

	tfc_ram #(.AW(tfc_pkg::CHAN_W), .DW(tfc_pkg::VAL_W)) u_start_ram (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (start_we),
		.wr_addr (start_wa),
		.wr_data (start_wd),
		.a_addr  (idx_q[0][7:0]),
		.a_data  (ram_rd[0]),
		.b_addr  (ptr_lookup_chan),
		.b_data  (ptr_lookup_value)
	);

	tfc_ram #(.AW(tfc_pkg::BLK_W), .DW(tfc_pkg::VAL_W)) u_link_ram (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (ram_we[1]),
		.wr_addr (idx_q[1]),
		.wr_data (data_q[1]),
		.a_addr  (idx_q[1]),
		.a_data  (ram_rd[1]),
		.b_addr  (link_lookup_block),
		.b_data  (link_lookup_next)
	);

	tfc_ram #(.AW(tfc_pkg::CHAN_W), .DW(tfc_pkg::VAL_W)) u_low_ram (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr_en   (ram_we[2]),
		.wr_addr (idx_q[2][7:0]),
		.wr_data (data_q[2]),
		.a_addr  (idx_q[2][7:0]),
		.a_data  (ram_rd[2]),
		.b_addr  (level_chan),
		.b_data  (low_mark_b)
	);

	// ---------------------------------------------------------------
	// low-watermark refill request
	// ---------------------------------------------------------------
	logic       level_valid_q;
	logic [7:0] level_chan_q;
	logic [9:0] level_count_q;
	logic       refill_req_q;
	logic [7:0] refill_chan_q;

	// equality, not less-or-equal: one request per crossing
	wire refill_hit = level_valid_q && (level_count_q == low_mark_b);

	assign refill_req  = refill_req_q;
	assign refill_chan = refill_chan_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_valid_q <= 1'h0;
			level_chan_q  <= 8'h00;
			level_count_q <= 10'h000;
			refill_req_q  <= 1'h0;
			refill_chan_q <= 8'h00;
		end else begin
			level_valid_q <= level_valid;
			level_chan_q  <= level_chan;
			level_count_q <= level_count;
			refill_req_q  <= refill_hit;
			if (refill_hit) begin
				refill_chan_q <= level_chan_q;
			end
		end
	end

	// ---------------------------------------------------------------
	// bus read channel
	// ---------------------------------------------------------------
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	wire [3:0]  rdec   = tfc_decode(araddr);
	wire [1:0]  rt     = rdec[3] ? rdec[1:0] : 2'h0;
	wire [31:0] sel_rd = {16'h0000, busy[rt], cmd_q[rt], 4'h0, idx_q[rt]};
	wire [31:0] dat_rd = {22'h000000, data_q[rt]};
	wire [31:0] rd_word = !rdec[3] ? 32'h00000000
	                    : (rdec[2] ? dat_rd : sel_rd);

	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'h0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= tfc_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'h1;
			rdata_q  <= rd_word;
			rresp_q  <= rdec[3] ? tfc_pkg::RESP_OKAY : tfc_pkg::RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'h0;
		end
	end

endmodule : tfc_top
